// *** hw/keypad_switch_display_scan.sv ***
// Design decisions made here: the register addresses and the plain strobed port.
`timescale 1ns/1ns
`include "scan_params.svh"

module keypad_switch_display_scan
  import scan_pkg::*;
(
  input wire logic sys_clk, // 50 MHz clock
  input wire logic rst, // Synchronous reset, high
  input wire logic [3:0] reg_addr, // Register word address
  input wire logic [15:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [15:0] reg_rdata, // Read data, cycle after strobe
  input wire logic scan_tick, // One pulse per program scan
  input wire logic [9:0] tk_pins, // Ten-key inputs, key n on bit n
  input wire logic [3:0] hex_ret_pins, // Hex matrix return lines
  input wire logic [7:0] dsw_pins, // Digit switch data lines
  output logic [4:0] hex_out, // Hex drive lines and pressed bit
  output logic [5:0] dsw_out, // Switch strobes, gate, round done
  output logic [12:0] seg_out, // Display data, latches, round done
  output logic hex_busy, // Hex reader executing
  output logic seg_busy, // Display driver executing
  output logic dsw_busy // Switch reader executing
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  logic [9:0] tk_keys;
  logic [3:0] hex_ret;
  logic [7:0] dsw_data;
  pin_sync #(.W(10)) u_tk_sync (.sys_clk(sys_clk), .rst(rst), .pin(tk_pins),
    .level(tk_keys));
  pin_sync #(.W(4)) u_hex_sync (.sys_clk(sys_clk), .rst(rst), .pin(hex_ret_pins),
    .level(hex_ret));
  pin_sync #(.W(8)) u_dsw_sync (.sys_clk(sys_clk), .rst(rst), .pin(dsw_pins),
    .level(dsw_data));
  digit_entry_if tk_ent ();
  digit_entry_if hex_ent ();
  digit_shifter u_tk_store (.sys_clk(sys_clk), .rst(rst), .ent(tk_ent.store));
  digit_shifter u_hex_store (.sys_clk(sys_clk), .rst(rst), .ent(hex_ent.store));
  // Register file
  word_t ctrl_ff, nxt_ctrl;
  word_t seg_lo_ff, nxt_seg_lo;
  word_t seg_hi_ff, nxt_seg_hi;
  word_t rdata_ff, nxt_rdata;
  logic [3:0] run, exec, first, act_ff, nxt_act;
  logic tk_lock_ff, nxt_tk_lock, tk_any;
  logic [9:0] tk_held_ff, nxt_tk_held;
  logic [3:0] tk_idx;
  hex_state_t hx_state_ff, nxt_hx_state, hx_cur;
  logic [1:0] hx_col_ff, nxt_hx_col, hx_row;
  logic [4:0] hex_out_ff, nxt_hex_out;
  logic [3:0] hx_cnt_ff, nxt_hx_cnt;
  logic [3:0] dsw_step_ff, nxt_dsw_step, dsw_step;
  logic dsw_eight_ff, nxt_dsw_eight;
  logic [5:0] dsw_out_ff, nxt_dsw_out;
  word_t dsw_lo_ff, nxt_dsw_lo, dsw_hi_ff, nxt_dsw_hi;
  logic [1:0] seg_dig_ff, nxt_seg_dig, seg_ph_ff, nxt_seg_ph, seg_dig, seg_ph;
  logic seg_done_ff, nxt_seg_done;
  logic [12:0] seg_out_ff, nxt_seg_out;
  logic [3:0] seg_strobe, seg_dinv, seg_linv;

  assign run = ctrl_ff[`CTRL_RUN_MSB:`CTRL_RUN_LSB];
  // R23 one step per scan
  assign exec = run & {4{scan_tick}};
  assign first = exec & ~act_ff;
  assign nxt_act = run & (act_ff | exec);

  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_seg_lo = seg_lo_ff;
    nxt_seg_hi = seg_hi_ff;
    nxt_rdata = 16'h0;
    if (reg_wr) begin
      case (reg_addr)
        `REG_CTRL: nxt_ctrl = reg_wdata;
        `REG_SEG_LO: nxt_seg_lo = reg_wdata;
        `REG_SEG_HI: nxt_seg_hi = reg_wdata;
        default: nxt_ctrl = ctrl_ff;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        `REG_CTRL: nxt_rdata = ctrl_ff;
        `REG_STATUS: nxt_rdata = {11'h0, hex_out_ff[4], tk_lock_ff, dsw_busy, seg_busy, hex_busy};
        // R4 value and key words
        `REG_TK_LO: nxt_rdata = tk_ent.value[15:0];
        `REG_TK_HI: nxt_rdata = tk_ent.value[31:16];
        `REG_TK_KEYS: nxt_rdata = {6'h0, tk_held_ff};
        `REG_HEX_LO: nxt_rdata = hex_ent.value[15:0];
        `REG_HEX_HI: nxt_rdata = hex_ent.value[31:16];
        `REG_DSW_LO: nxt_rdata = dsw_lo_ff;
        `REG_DSW_HI: nxt_rdata = dsw_hi_ff;
        `REG_SEG_LO: nxt_rdata = seg_lo_ff;
        `REG_SEG_HI: nxt_rdata = seg_hi_ff;
        default: nxt_rdata = 16'h0;
      endcase
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_ff <= `CTRL_RESET;
      seg_lo_ff <= 16'h0;
      seg_hi_ff <= 16'h0;
      rdata_ff <= 16'h0;
      act_ff <= 4'h0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      seg_lo_ff <= nxt_seg_lo;
      seg_hi_ff <= nxt_seg_hi;
      rdata_ff <= nxt_rdata;
      act_ff <= nxt_act;
    end
  end
  // Ten-key reader
  always_comb begin
    tk_idx = 4'h0;
    tk_any = 1'b0;
    nxt_tk_lock = tk_lock_ff;
    nxt_tk_held = tk_held_ff;
    tk_ent.push = 1'b0;
    // R1 lowest pressed key
    for (int i = 9; i >= 0; i--) begin
      if (tk_keys[i]) begin
        tk_idx = 4'(i);
        tk_any = 1'b1;
      end
    end
    tk_ent.digit = tk_idx;
    if (exec[`FN_TK]) begin
      // R2 held key locks out
      if (tk_lock_ff && !first[`FN_TK]) begin
        if ((tk_keys & tk_held_ff) == 10'h0) begin
          nxt_tk_lock = 1'b0;
          nxt_tk_held = 10'h0;
        end
      end else if (tk_any) begin
        tk_ent.push = 1'b1;
        nxt_tk_lock = 1'b1;
        nxt_tk_held = 10'h1 << tk_idx;
      end else begin
        nxt_tk_lock = 1'b0;
        nxt_tk_held = 10'h0;
      end
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tk_lock_ff <= 1'b0;
      tk_held_ff <= 10'h0;
    end else begin
      tk_lock_ff <= nxt_tk_lock;
      tk_held_ff <= nxt_tk_held;
    end
  end
  // Hex matrix reader
  always_comb begin
    hx_cur = first[`FN_HEX] ? HX_IDLE : hx_state_ff;
    nxt_hx_state = hx_state_ff;
    nxt_hx_col = hx_col_ff;
    nxt_hex_out = hex_out_ff;
    nxt_hx_cnt = hx_cnt_ff;
    hx_row = 2'h0;
    for (int i = 3; i >= 0; i--) begin
      if (hex_ret[i]) begin
        hx_row = 2'(i);
      end
    end
    hex_ent.push = 1'b0;
    // R5 key code from column and row
    hex_ent.digit = {hx_col_ff, hx_row};
    if (exec[`FN_HEX]) begin
      unique case (hx_cur)
        HX_IDLE: begin
          nxt_hx_state = HX_IDLE;
          nxt_hex_out = 5'h0f;
          if (hex_ret != 4'h0 && !first[`FN_HEX]) begin
            nxt_hx_state = HX_PROBE;
            nxt_hx_col = 2'h0;
            nxt_hx_cnt = 4'h1;
            nxt_hex_out = 5'h11;
          end
        end
        HX_PROBE: begin
          // R7 columns driven in turn
          nxt_hx_cnt = hx_cnt_ff + 4'h1;
          if (hex_ret != 4'h0) begin
            hex_ent.push = 1'b1;
            nxt_hx_state = HX_HOLD;
            nxt_hex_out = 5'h1f;
          end else if (hx_col_ff == 2'h3) begin
            nxt_hx_state = HX_IDLE;
            nxt_hex_out = 5'h0f;
          end else begin
            nxt_hx_col = hx_col_ff + 2'h1;
            nxt_hex_out = {1'b1, 4'h1 << nxt_hx_col};
          end
        end
        HX_HOLD: begin
          // R6 pressed bit until release
          if (hex_ret == 4'h0) begin
            nxt_hx_state = HX_IDLE;
            nxt_hex_out = 5'h0f;
          end
        end
      endcase
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      hx_state_ff <= HX_IDLE;
      hx_col_ff <= 2'h0;
      hex_out_ff <= 5'h00;
      hx_cnt_ff <= 4'h0;
    end else begin
      hx_state_ff <= nxt_hx_state;
      hx_col_ff <= nxt_hx_col;
      hex_out_ff <= nxt_hex_out;
      hx_cnt_ff <= nxt_hx_cnt;
    end
  end
  // Digit switch reader, four scans per strobe
  always_comb begin
    dsw_step = first[`FN_DSW] ? 4'h0 : dsw_step_ff;
    nxt_dsw_eight = first[`FN_DSW] ? ctrl_ff[`CTRL_DSW_EIGHT] : dsw_eight_ff;
    nxt_dsw_step = dsw_step_ff;
    nxt_dsw_out = dsw_out_ff;
    nxt_dsw_lo = dsw_lo_ff;
    nxt_dsw_hi = dsw_hi_ff;
    if (exec[`FN_DSW]) begin
      // R10 strobe, gate, read, release
      case (dsw_step[1:0])
        2'h0: nxt_dsw_out[4:0] = {1'b0, 4'h1 << dsw_step[3:2]};
        2'h1: nxt_dsw_out[4] = 1'b1;
        2'h2: begin
          // R11 low digits on bits 0-3
          nxt_dsw_lo[{dsw_step[3:2], 2'b00} +: 4] = dsw_data[3:0];
          if (nxt_dsw_eight) begin
            nxt_dsw_hi[{dsw_step[3:2], 2'b00} +: 4] = dsw_data[7:4];
          end
        end
        2'h3: nxt_dsw_out[4:0] = 5'h00;
      endcase
      // R12 round done pulse
      nxt_dsw_out[5] = (dsw_step == `DSW_ROUND_LAST);
      // R13 sixteen-scan round
      nxt_dsw_step = dsw_step + 4'h1;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dsw_step_ff <= 4'h0;
      dsw_eight_ff <= 1'b0;
      dsw_out_ff <= 6'h00;
      dsw_lo_ff <= 16'h0;
      dsw_hi_ff <= 16'h0;
    end else begin
      dsw_step_ff <= nxt_dsw_step;
      dsw_eight_ff <= nxt_dsw_eight;
      dsw_out_ff <= nxt_dsw_out;
      dsw_lo_ff <= nxt_dsw_lo;
      dsw_hi_ff <= nxt_dsw_hi;
    end
  end
  // Display driver, three scans per digit
  always_comb begin
    seg_dig = first[`FN_SEG] ? 2'h0 : seg_dig_ff;
    seg_ph = first[`FN_SEG] ? 2'h0 : seg_ph_ff;
    nxt_seg_dig = seg_dig_ff;
    nxt_seg_ph = seg_ph_ff;
    nxt_seg_done = first[`FN_SEG] ? 1'b0 : seg_done_ff;
    nxt_seg_out = seg_out_ff;
    // R20 polarity from control value
    seg_dinv = {4{ctrl_ff[`CTRL_SEG_DATA_INV]}};
    seg_linv = {4{ctrl_ff[`CTRL_SEG_LATCH_INV]}};
    seg_strobe = (seg_ph == 2'h1) ? (4'h1 << seg_dig) : 4'h0;
    if (exec[`FN_SEG]) begin
      if (seg_ph == `SEG_LAST_PHASE && seg_dig == `SEG_LAST_DIGIT) begin
        nxt_seg_done = 1'b1;
      end
      // R19 right digits from first word
      if (ctrl_ff[`CTRL_SEG_EIGHT]) begin
        // R16 twelve outputs, R18 done on bit 12
        nxt_seg_out = {nxt_seg_done, seg_strobe ^ seg_linv,
                       seg_hi_ff[{seg_dig, 2'b00} +: 4] ^ seg_dinv,
                       seg_lo_ff[{seg_dig, 2'b00} +: 4] ^ seg_dinv};
      end else begin
        // R17 data 0-3, latches 4-7, done on bit 8
        nxt_seg_out = {4'h0, nxt_seg_done, seg_strobe ^ seg_linv,
                       seg_lo_ff[{seg_dig, 2'b00} +: 4] ^ seg_dinv};
      end
      // R21 twelve-scan round repeats
      if (seg_ph == `SEG_LAST_PHASE) begin
        nxt_seg_ph = 2'h0;
        nxt_seg_dig = seg_dig + 2'h1;
      end else begin
        nxt_seg_ph = seg_ph + 2'h1;
        nxt_seg_dig = seg_dig;
      end
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      seg_dig_ff <= 2'h0;
      seg_ph_ff <= 2'h0;
      seg_done_ff <= 1'b0;
      seg_out_ff <= 13'h0000;
    end else begin
      seg_dig_ff <= nxt_seg_dig;
      seg_ph_ff <= nxt_seg_ph;
      seg_done_ff <= nxt_seg_done;
      seg_out_ff <= nxt_seg_out;
    end
  end
  assign reg_rdata = rdata_ff;
  assign hex_out = hex_out_ff;
  assign dsw_out = dsw_out_ff;
  assign seg_out = seg_out_ff;
  // R8 hex busy flag
  assign hex_busy = run[`FN_HEX];
  // R22 display busy flag
  assign seg_busy = run[`FN_SEG];
  // R14 switch busy flag
  assign dsw_busy = run[`FN_DSW];
  sequence s_dsw_last;
    exec[`FN_DSW] && !first[`FN_DSW] && dsw_step_ff == `DSW_ROUND_LAST;
  endsequence
  sequence s_dsw_pulse;
    dsw_out_ff[5] && dsw_step_ff == 4'h0;
  endsequence
  property p_dsw_round;
    s_dsw_last |=> s_dsw_pulse;
  endproperty
  a_dsw_round: assert property (p_dsw_round) else $error("switch round end missed"); // R13
  property p_dsw_pulse_once;
    exec[`FN_DSW] && dsw_out_ff[5] |=> !dsw_out_ff[5];
  endproperty
  a_dsw_pulse_once: assert property (p_dsw_pulse_once) else $error("round pulse held"); // R12
  property p_tk_lock;
    tk_ent.push |-> !tk_lock_ff || first[`FN_TK];
  endproperty
  a_tk_lock: assert property (p_tk_lock) else $error("key accepted while locked"); // R2
  property p_tk_status;
    tk_ent.push |=> tk_held_ff == (10'h1 << $past(tk_idx)) && tk_lock_ff;
  endproperty
  a_tk_status: assert property (p_tk_status) else $error("key status not recorded"); // R4
  property p_hex_led;
    hex_out_ff[4] == (hx_state_ff != HX_IDLE);
  endproperty
  a_hex_led: assert property (p_hex_led) else $error("pressed bit wrong"); // R6
  property p_hex_bound;
    hx_state_ff == HX_PROBE |-> hx_cnt_ff < `HEX_MAX_CYCLES - 4'h6;
  endproperty
  a_hex_bound: assert property (p_hex_bound) else $error("hex resolve too slow"); // R7
  property p_hex_push;
    hex_ent.push |=> hx_state_ff == HX_HOLD && hex_out_ff == 5'h1f;
  endproperty
  a_hex_push: assert property (p_hex_push) else $error("hex key not held"); // R5
  property p_seg_restart;
    first[`FN_SEG] |=> seg_dig_ff == 2'h0 && seg_ph_ff == 2'h1 && !seg_done_ff;
  endproperty
  a_seg_restart: assert property (p_seg_restart) else $error("display not restarted"); // R23
  property p_seg_done;
    exec[`FN_SEG] && !first[`FN_SEG] && seg_dig_ff == 2'h3 && seg_ph_ff == 2'h2
      |=> seg_done_ff && seg_dig_ff == 2'h0 && seg_ph_ff == 2'h0;
  endproperty
  a_seg_done: assert property (p_seg_done) else $error("display round end wrong"); // R21
endmodule : keypad_switch_display_scan

// *** hw/scan_params.svh ***
`ifndef SCAN_PARAMS_SVH
`define SCAN_PARAMS_SVH
// Notes on behaviour
// R1: Ten-key reader takes up to 8 BCD digits, keys 0-9 on input bits 0-9.
// R2: While one key is held, every other key is ignored until release.
// R3: A ninth digit shifts out the oldest digit; at most eight digits remain.
// R4: Ten-key value sits in two words; held-key information in a separate word.
// R5: Hex reader scans 16 keys: 4 return inputs, 5 outputs, 8 hex digits.
// R6: Hex reader drives output bit 4 high while any key is pressed.
// R7: Hex reader resolves a key within 3 to 12 scans by driving columns in turn.
// R8: Hex scan busy flag is set while the hex reader executes.
// R9: Configuring party sets the input filter shorter than one scan cycle.
// R10: Switch reader reads 4 or 8 BCD digits with 5 strobes, 4 or 8 inputs; the code drives 4 strobes (bits 0-3) and a gate on bit 4.
// R11: Four-digit switch data arrives on input bits 0 to 3.
// R12: Switch reader pulses output bit 5 after each complete round.
// R13: One switch reading round lasts 16 scan cycles.
// R14: Switch reader busy flag is set while the switch reader executes.
// R15: Digit count is chosen by software before the switch reader first runs.
// R16: Display uses 8 outputs for four digits, 12 for eight digits.
// R17: Four-digit display: data on bits 0-3, latch strobes on bits 4-7.
// R18: Round-complete output on bit 12 (eight digits) or bit 8 (four digits).
// R19: Right four digits from first source word, left four from the next.
// R20: Control 0-7 selects digit count, data polarity and latch polarity.
// R21: Display refreshes all digits in 12 scan cycles, repeating forever.
// R22: Display busy flag is set while the display driver executes.
// R23: Each sequencer steps once per executed scan and restarts on first execution.

// Register offsets (word addresses)
`define REG_CTRL 4'h0
`define REG_STATUS 4'h1
`define REG_TK_LO 4'h2
`define REG_TK_HI 4'h3
`define REG_TK_KEYS 4'h4
`define REG_HEX_LO 4'h5
`define REG_HEX_HI 4'h6
`define REG_DSW_LO 4'h7
`define REG_DSW_HI 4'h8
`define REG_SEG_LO 4'h9
`define REG_SEG_HI 4'ha

// Control word fields
`define CTRL_RUN_LSB 0
`define CTRL_RUN_MSB 3
`define CTRL_DSW_EIGHT 4
`define CTRL_SEG_LATCH_INV 8
`define CTRL_SEG_DATA_INV 9
`define CTRL_SEG_EIGHT 10
`define CTRL_RESET 16'h0000

// Function index within run, exec and first vectors
`define FN_TK 0
`define FN_HEX 1
`define FN_DSW 2
`define FN_SEG 3

// Status word fields
`define STAT_HEX_BUSY 0
`define STAT_SEG_BUSY 1
`define STAT_DSW_BUSY 2
`define STAT_TK_LOCK 3
`define STAT_HEX_PRESSED 4

// Flag bit addresses seen by the program
`define FLAG_HEX_ADDR 25408
`define FLAG_SEG_ADDR 25409
`define FLAG_DSW_ADDR 25410

// Sequencing counts in scan cycles
`define HEX_MIN_CYCLES 4'h3
`define HEX_MAX_CYCLES 4'hc
`define DSW_ROUND_LAST 4'hf
`define SEG_LAST_DIGIT 2'h3
`define SEG_LAST_PHASE 2'h2
`endif

// *** hw/scan_pkg.sv ***
package scan_pkg;
  typedef logic [15:0] word_t;
  typedef logic [31:0] dword_t;
  typedef enum logic [2:0] {
    HX_IDLE = 3'b001,
    HX_PROBE = 3'b010,
    HX_HOLD = 3'b100
  } hex_state_t;
endpackage : scan_pkg

// *** hw/digit_entry_if.sv ***
`timescale 1ns/1ns
interface digit_entry_if;
  logic push;
  logic [3:0] digit;
  logic [31:0] value;
  modport feeder (output push, output digit, input value);
  modport store (input push, input digit, output value);
endinterface : digit_entry_if

// *** hw/digit_shifter.sv ***
`timescale 1ns/1ns
module digit_shifter
  import scan_pkg::*;
(
  input wire logic sys_clk, // Clock
  input wire logic rst, // Synchronous reset
  digit_entry_if.store ent // Digit stream in, eight-digit value out
);
  dword_t value_ff;
  dword_t nxt_value;

  always_comb begin
    nxt_value = value_ff;
    // R3 oldest digit drops
    if (ent.push) begin
      nxt_value = {value_ff[27:0], ent.digit};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      value_ff <= 32'h0;
    end else begin
      value_ff <= nxt_value;
    end
  end

  assign ent.value = value_ff;

  property p_shift_in;
    @(posedge sys_clk) disable iff (rst)
      ent.push |=> value_ff == {$past(value_ff[27:0]), $past(ent.digit)};
  endproperty
  a_shift_in: assert property (p_shift_in) else $error("digit not shifted in"); // R3
endmodule : digit_shifter

// *** hw/pin_sync.sv ***
`timescale 1ns/1ns
module pin_sync #(
  parameter int W = 4
) (
  input wire logic sys_clk, // Clock
  input wire logic rst, // Synchronous reset
  input wire logic [W-1:0] pin, // Raw pin levels
  output logic [W-1:0] level // Accepted levels
);
  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  logic [W-1:0] level_ff;
  logic [W-1:0] nxt_level;

  // A bit changes only when stages two and three agree
  always_comb begin
    nxt_level = (~(s2_ff ^ s3_ff) & s3_ff) | ((s2_ff ^ s3_ff) & level_ff);
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      level_ff <= '0;
    end else begin
      s1_ff <= pin;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      level_ff <= nxt_level;
    end
  end

  assign level = level_ff;

  property p_agree;
    @(posedge sys_clk) disable iff (rst)
      (level_ff != $past(level_ff)) |->
        ((level_ff ^ $past(level_ff)) & $past(s2_ff ^ s3_ff)) == '0 || $past(rst);
  endproperty
  a_agree: assert property (p_agree) else $error("level changed without agreement");
endmodule : pin_sync

// *** dv/scan_far_side.sv ***
`timescale 1ns/1ns
module scan_far_side (
  input wire logic sys_clk, // Clock
  input wire logic [3:0] hex_key, // Held hex key, col*4+row
  input wire logic hex_down, // Hex key held
  input wire logic [4:0] hex_out, // Column drives
  output logic [3:0] hex_ret_pins, // Return lines
  input wire logic [31:0] sw_val, // Switch settings
  input wire logic [5:0] dsw_out, // Switch strobes
  output logic [7:0] dsw_pins, // Switch data
  input wire logic [12:0] seg_out, // Display lines
  input wire logic [2:0] seg_c, // Digits and polarity
  output logic [31:0] shown // Latched display digits
);
  logic [7:0] noise_ff = 8'h00;
  logic [3:0] lat;
  int d;
  assign hex_ret_pins = (hex_down && hex_out[hex_key[3:2]]) ? 4'h1 << hex_key[1:0] : 4'h0;
  always_comb begin
    dsw_pins = noise_ff;
    for (int i = 0; i < 4; i++) begin
      if (dsw_out[i]) begin
        dsw_pins = {sw_val[16+4*i+:4], sw_val[4*i+:4]};
      end
    end
  end
  assign lat = (seg_c[2] ? seg_out[11:8] : seg_out[7:4]) ^ {4{seg_c[0]}};
  always @(posedge sys_clk) begin
    noise_ff <= noise_ff + 8'h3b;
    for (d = 0; d < 4; d++) begin
      if (lat[d]) begin
        shown[4*d+:4] <= seg_out[3:0] ^ {4{seg_c[1]}};
        shown[16+4*d+:4] <= seg_out[7:4] ^ {4{seg_c[1]}};
      end
    end
  end
endmodule : scan_far_side

// *** dv/tb.sv ***
`timescale 1ns/1ns
`include "scan_params.svh"
module tb;
  import scan_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  word_t reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  word_t reg_rdata;
  logic scan_tick = 1'b0;
  logic [9:0] tk_pins = 10'h000;
  logic [3:0] hex_ret_pins;
  logic [3:0] hex_key = 4'h0;
  logic hex_down = 1'b0;
  logic [7:0] dsw_pins;
  logic [4:0] hex_out;
  logic [5:0] dsw_out;
  logic [12:0] seg_out;
  logic hex_busy, seg_busy, dsw_busy;
  logic [2:0] seg_c = 3'h0;
  dword_t sw_val = 32'h0;
  dword_t shown, acc, v;
  word_t exp_q[$];
  logic rd_seen = 1'b0;
  int failures = 0;
  int tests_run = 0;
  int cyc = 0;
  int i, c;
  integer seed = 32'hb8d0;

  keypad_switch_display_scan keypad_switch_display_scan_i (.sys_clk, .rst, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .scan_tick, .tk_pins, .hex_ret_pins,
    .dsw_pins, .hex_out, .dsw_out, .seg_out, .hex_busy, .seg_busy, .dsw_busy);
  scan_far_side scan_far_side_i (.sys_clk, .hex_key, .hex_down, .hex_out, .hex_ret_pins,
    .sw_val, .dsw_out, .dsw_pins, .seg_out, .seg_c, .shown);

  always #10 sys_clk = ~sys_clk;

  task automatic chk(input dword_t got, input dword_t exp, input string what);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic finish_test;
    $display("tests_run %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finish_test

  task automatic wr(input logic [3:0] a, input word_t dat);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= dat;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input word_t e);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    exp_q.push_back(e);
    @(posedge sys_clk);
    reg_rd <= 1'b0;
  endtask : rd

  task automatic scans(input int n);
    repeat (n) begin
      repeat (6) @(posedge sys_clk);
      scan_tick <= 1'b1;
      @(posedge sys_clk);
      scan_tick <= 1'b0;
      @(posedge sys_clk);
    end
  endtask : scans

  task automatic key(input int k);
    tk_pins <= 10'h001 << k;
    scans(1);
    tk_pins <= 10'h000;
    scans(1);
  endtask : key

  // Read data checked in the cycle after the strobe
  always @(posedge sys_clk) begin
    if (rd_seen) chk(reg_rdata, exp_q.pop_front(), "read");
    rd_seen <= reg_rd;
  end

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 6000) begin
      failures++;
      finish_test();
    end
  end

  initial begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    rd(`REG_CTRL, 16'h0000);
    wr(`REG_TK_LO, 16'h1234);
    rd(`REG_TK_LO, 16'h0000);
    rd(4'hf, 16'h0000);
    wr(`REG_CTRL, 16'h000e);
    rd(`REG_STATUS, 16'h0007);
    chk({hex_busy, seg_busy, dsw_busy}, 3'b111, "busy");
    wr(`REG_CTRL, 16'h0000);
    rd(`REG_STATUS, 16'h0000);
    $display("register test done");
    wr(`REG_CTRL, 16'h0001);
    tk_pins <= 10'h008;
    scans(1);
    rd(`REG_TK_LO, 16'h0003);
    rd(`REG_TK_KEYS, 16'h0008);
    rd(`REG_STATUS, 16'h0008);
    tk_pins <= 10'h028;
    scans(2);
    rd(`REG_TK_LO, 16'h0003);
    tk_pins <= 10'h000;
    scans(1);
    acc = 32'h3;
    for (i = 0; i < 9; i++) begin
      c = $unsigned($random(seed)) % 10;
      acc = {acc[27:0], c[3:0]};
      key(c);
    end
    rd(`REG_TK_LO, acc[15:0]);
    rd(`REG_TK_HI, acc[31:16]);
    $display("ten-key test done");
    wr(`REG_CTRL, 16'h0002);
    scans(1);
    chk(hex_out, 5'h0f, "hex idle");
    hex_key <= 4'h9;
    hex_down <= 1'b1;
    scans(6);
    chk(hex_out, 5'h1f, "hex held");
    rd(`REG_STATUS, 16'h0011);
    hex_down <= 1'b0;
    scans(2);
    chk(hex_out, 5'h0f, "hex release");
    hex_key <= 4'h3;
    hex_down <= 1'b1;
    scans(6);
    hex_down <= 1'b0;
    scans(2);
    rd(`REG_HEX_LO, 16'h0093);
    $display("hex test done");
    for (i = 0; i < 2; i++) begin
      for (c = 0; c < 8; c++) v[4*c+:4] = $unsigned($random(seed)) % 10;
      sw_val <= v;
      wr(`REG_CTRL, i ? 16'h0014 : 16'h0004);
      scans(5);
      wr(`REG_CTRL, 16'h0000);
      wr(`REG_CTRL, i ? 16'h0014 : 16'h0004);
      scans(15);
      chk(dsw_out[5], 1'b0, "dsw early");
      scans(1);
      chk(dsw_out[5], 1'b1, "dsw done");
      rd(`REG_DSW_LO, v[15:0]);
      if (i) rd(`REG_DSW_HI, v[31:16]);
    end
    $display("switch test done");
    for (c = 0; c < 8; c++) begin
      v = $random(seed);
      seg_c <= c[2:0];
      wr(`REG_SEG_LO, v[15:0]);
      wr(`REG_SEG_HI, v[31:16]);
      wr(`REG_CTRL, 16'h0000);
      wr(`REG_CTRL, {5'h00, c[2:0], 8'h08});
      scans(11);
      chk(c[2] ? seg_out[12] : seg_out[8], 1'b0, "seg early");
      scans(1);
      chk(c[2] ? seg_out[12] : seg_out[8], 1'b1, "seg done");
      chk(c[2] ? shown : shown[15:0], c[2] ? v : v[15:0], "seg digits");
    end
    $display("display test done");
    repeat (3) @(posedge sys_clk);
    finish_test();
  end
endmodule : tb
